// file: hw/sep_consts.svh
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
// Operation
// [RULE1] Timeout flag sets on a failed operation; resets to zero, cleared by writing one.
// [RULE2] A write not acknowledged within 30 ms is abandoned, flagged, controller idles.
// [RULE3] Loaded flag sets only after a valid EEPROM loaded normally.
// [RULE4] Loaded flag clears on every reset and when a reload starts; resets to zero.
// [RULE5] Writing one clears the loaded flag; writing zero leaves it alone.
// [RULE6] Sixteen-bit byte address selects the EEPROM location; resets to zero.
// [RULE7] Data register holds read or to-be-written byte in bits 7:0; upper bits zero.
// [RULE8] Read command fetches the addressed byte into the data register.
// [RULE9] Unsupported command clears busy and sets the timeout flag.
// [RULE10] Read-only overflow flag sets when the loader would read past the EEPROM end.
// [RULE11] Each access is an I2C master transaction; missing acknowledge ends in timeout.

// ==========================================================
// Register map (byte addresses)
`define SEP_OFF_CMD    12'h1b4
`define SEP_OFF_DATA   12'h1b8
`define SEP_OFF_IST    12'h1bc
`define SEP_OFF_IMSK   12'h1c0

// ==========================================================
// Command register fields
`define SEP_B_BUSY     31
`define SEP_CMD_HI     30
`define SEP_CMD_LO     28
`define SEP_B_OVF      18
`define SEP_B_TO       17
`define SEP_B_LD       16
`define SEP_CMD_READ   3'h0
`define SEP_CMD_WRITE  3'h3
`define SEP_CMD_RELOAD 3'h7
`define SEP_ADDR_RST   16'h0000
`define SEP_DATA_RST   8'h00

// ==========================================================
// Interrupt status bits
`define SEP_IRQ_DONE   0
`define SEP_IRQ_TO     1
`define SEP_IRQ_LD     2
`define SEP_IRQ_RST    3'h0

// ==========================================================
// I2C protocol constants and sequence steps
`define SEP_DEV_WR     8'ha0
`define SEP_DEV_RD     8'ha1
`define SEP_SIG        8'ha5
`define SEP_HDR_LEN    32'h3
`define SEP_STEP_POLL  4'h6
`define SEP_STEP_PADR  4'h7

// ==========================================================
// Timing
`define SEP_CLK_KHZ    100000
`define SEP_SCL_KHZ    100
`define SEP_WR_TO_MS   30
`define SEP_EE_BYTES   65536
`endif

// file: hw/sep_pkg.sv
package sep_pkg;
  typedef enum logic [2:0] {SEP_A_START, SEP_A_TX, SEP_A_RXACK, SEP_A_RXNACK, SEP_A_STOP, SEP_A_END} sep_act_t;
  typedef enum logic [1:0] {SEP_IDLE, SEP_ISSUE, SEP_EXEC} sep_state_t;
endpackage

// file: hw/sep_top.sv
`timescale 1ns/1ns
`include "sep_consts.svh"
module sep_top
  import sep_pkg::*;
#(
  parameter int QCYC      = `SEP_CLK_KHZ / (4 * `SEP_SCL_KHZ),
  parameter int WR_TO_CYC = `SEP_WR_TO_MS * `SEP_CLK_KHZ,
  parameter int EE_BYTES  = `SEP_EE_BYTES
) (
  // System
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [11:0] i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // I2C pins, enable high pulls the line low
  input  wire logic        i_sda,
  output logic             o_sda_oe,
  output logic             o_scl_oe,
  // Interrupt
  output logic             o_irq
);

  // ==========================================================
  // Sequence tables
  function automatic sep_act_t act_of(input logic [2:0] c, input logic [3:0] s);
    sep_act_t a;
    a = SEP_A_END;
    case (c)
      `SEP_CMD_READ: begin
        if (s == 4'h0 || s == 4'h4) a = SEP_A_START;
        else if (s <= 4'h5) a = SEP_A_TX;
        else if (s == 4'h6) a = SEP_A_RXNACK;
        else if (s == 4'h7) a = SEP_A_STOP;
      end
      `SEP_CMD_WRITE: begin
        if (s == 4'h0 || s == 4'h6) a = SEP_A_START;
        else if (s <= 4'h4 || s == 4'h7) a = SEP_A_TX;
        else if (s == 4'h5 || s == 4'h8) a = SEP_A_STOP;
      end
      default: begin
        if (s == 4'h0 || s == 4'h4) a = SEP_A_START;
        else if (s <= 4'h5) a = SEP_A_TX;
        else if (s <= 4'h7) a = SEP_A_RXACK;
        else if (s == 4'h8) a = SEP_A_RXNACK;
        else if (s == 4'h9) a = SEP_A_STOP;
      end
    endcase
    return a;
  endfunction

  function automatic logic s_byte_dev_wr(input logic [2:0] c, input logic [3:0] s);
    return (s == 4'h1) || (c == `SEP_CMD_WRITE && s == `SEP_STEP_PADR);
  endfunction

  // ==========================================================
  // State
  sep_state_t  state, next_state;
  sep_act_t    act, next_act;
  logic        sda_meta, sda_sync;
  logic [15:0] div, next_div;
  logic [1:0]  qcnt, next_qcnt;
  logic [3:0]  bcnt, next_bcnt;
  logic [8:0]  shift, next_shift;
  logic [3:0]  step, next_step;
  logic [2:0]  cmd, next_cmd;
  logic        busy, next_busy;
  logic        abort, next_abort;
  logic        retry, next_retry;
  logic        boot, next_boot;
  logic [31:0] wr_cnt, next_wr_cnt;
  logic [15:0] addr, next_addr;
  logic [7:0]  data, next_data;
  logic        cmd_to, next_cmd_to;
  logic        cfg_ld, next_cfg_ld;
  logic        ovf, next_ovf;
  logic [7:0]  ld_sig, next_ld_sig;
  logic [15:0] ld_len, next_ld_len;
  logic [2:0]  ist, next_ist;
  logic [2:0]  imsk, next_imsk;
  logic [31:0] next_wb_dat;
  logic        next_wb_ack, next_sda_oe, next_scl_oe, next_irq;
  logic        tick, fin, fail_evt, wr, req;
  logic [8:0]  sh;
  logic [7:0]  txb;
  sep_act_t    a;

  // ==========================================================
  // Pin synchroniser
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= i_sda;
      sda_sync <= sda_meta;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_state = state;   next_act = act;       next_div = div;
    next_qcnt = qcnt;     next_bcnt = bcnt;     next_shift = shift;
    next_step = step;     next_cmd = cmd;       next_busy = busy;
    next_abort = abort;   next_retry = retry;   next_boot = boot;
    next_addr = addr;     next_data = data;     next_cmd_to = cmd_to;
    next_cfg_ld = cfg_ld; next_ovf = ovf;       next_ld_sig = ld_sig;
    next_ld_len = ld_len; next_ist = ist;       next_imsk = imsk;
    next_sda_oe = o_sda_oe;
    next_scl_oe = o_scl_oe;
    fin = 1'b0;
    fail_evt = 1'b0;
    sh = shift;
    a = act_of(cmd, step);
    txb = data;
    tick = (div == 16'h0);
    next_div = tick ? 16'(QCYC - 1) : div - 16'h1;
    // Write-poll window counts only while polling for the ack
    next_wr_cnt = (busy && cmd == `SEP_CMD_WRITE && step >= `SEP_STEP_POLL) ? wr_cnt + 32'h1 : 32'h0;

    // Bus slave: answer one cycle after the request, effect on the acking edge
    req = i_wb_cyc & i_wb_stb;
    wr = req & i_wb_we & o_wb_ack;
    next_wb_ack = req & ~o_wb_ack;
    next_wb_dat = 32'h0;
    if (req && !o_wb_ack) begin
      case (i_wb_adr)
        `SEP_OFF_CMD: begin
          next_wb_dat[`SEP_B_BUSY] = busy;
          next_wb_dat[`SEP_CMD_HI:`SEP_CMD_LO] = cmd;
          next_wb_dat[`SEP_B_OVF] = ovf;
          next_wb_dat[`SEP_B_TO] = cmd_to;
          next_wb_dat[`SEP_B_LD] = cfg_ld;
          next_wb_dat[15:0] = addr;
        end
        `SEP_OFF_DATA: next_wb_dat[7:0] = data; // RULE7
        `SEP_OFF_IST:  next_wb_dat[2:0] = ist;
        `SEP_OFF_IMSK: next_wb_dat[2:0] = imsk;
        default:       next_wb_dat = 32'h0;
      endcase
    end

    if (s_byte_dev_wr(cmd, step)) txb = `SEP_DEV_WR;
    else if (step == 4'h5) txb = `SEP_DEV_RD;
    else if (step == 4'h2) txb = (cmd == `SEP_CMD_RELOAD) ? 8'h00 : addr[15:8]; // RULE6
    else if (step == 4'h3) txb = (cmd == `SEP_CMD_RELOAD) ? 8'h00 : addr[7:0];

    case (state)
      SEP_IDLE: begin
        if (boot) begin
          next_boot = 1'b0;
          next_cmd = `SEP_CMD_RELOAD;
          next_busy = 1'b1;
          next_step = 4'h0;
          next_abort = 1'b0;
          next_retry = 1'b0;
          next_cfg_ld = 1'b0; // RULE4
          next_ovf = 1'b0;
          next_state = SEP_ISSUE;
        end
      end
      SEP_ISSUE: begin
        if (cmd == `SEP_CMD_WRITE && step == `SEP_STEP_POLL && wr_cnt >= WR_TO_CYC) begin
          fin = 1'b1; // RULE2
          fail_evt = 1'b1;
        end else if (!abort && a == SEP_A_END) begin
          fin = 1'b1;
        end else begin
          next_act = abort ? SEP_A_STOP : a;
          next_qcnt = 2'h0;
          next_bcnt = 4'h0;
          next_div = 16'(QCYC - 1);
          next_shift = (a == SEP_A_TX) ? {txb, 1'b1} : {8'hff, a == SEP_A_RXNACK};
          next_state = SEP_EXEC;
        end
      end
      SEP_EXEC: begin
        if (tick) begin
          next_qcnt = qcnt + 2'h1;
          if (act == SEP_A_START) begin
            if (qcnt == 2'h0) begin
              next_scl_oe = 1'b0;
              next_sda_oe = 1'b0;
            end else if (qcnt == 2'h1) begin
              next_sda_oe = 1'b1;
            end else begin
              next_scl_oe = 1'b1;
              next_step = step + 4'h1;
              next_state = SEP_ISSUE;
            end
          end else if (act == SEP_A_STOP) begin
            if (qcnt == 2'h0) begin
              next_scl_oe = 1'b1;
              next_sda_oe = 1'b1;
            end else if (qcnt == 2'h1) begin
              next_scl_oe = 1'b0;
            end else begin
              next_sda_oe = 1'b0;
              next_state = SEP_ISSUE;
              if (abort) begin
                fin = 1'b1; // RULE11
                fail_evt = 1'b1;
              end else if (retry) begin
                next_retry = 1'b0;
                next_step = `SEP_STEP_POLL;
              end else begin
                next_step = step + 4'h1;
              end
            end
          end else begin
            case (qcnt)
              2'h0: begin
                next_scl_oe = 1'b1;
                next_sda_oe = ~shift[8];
              end
              2'h1: next_scl_oe = 1'b0;
              2'h2: next_shift = {shift[7:0], sda_sync};
              default: begin
                next_scl_oe = 1'b1;
                next_bcnt = bcnt + 4'h1;
                if (bcnt == 4'h8) begin
                  // SDA held: freeing it as SCL falls could look like a stop
                  next_step = step + 4'h1;
                  next_state = SEP_ISSUE;
                  sh = shift;
                  if (act == SEP_A_TX && sh[0]) begin
                    if (cmd == `SEP_CMD_WRITE && step == `SEP_STEP_PADR) next_retry = 1'b1;
                    else next_abort = 1'b1; // RULE11
                  end
                  if (act != SEP_A_TX) begin
                    if (cmd == `SEP_CMD_READ) next_data = sh[8:1]; // RULE8
                    else if (step == 4'h6) next_ld_sig = sh[8:1];
                    else if (step == 4'h7) next_ld_len[15:8] = sh[8:1];
                    else next_ld_len[7:0] = sh[8:1];
                  end
                end
              end
            endcase
          end
        end
      end
      default: next_state = SEP_IDLE;
    endcase

    // Software writes; flag clears come before hardware sets so a set wins
    if (wr) begin
      case (i_wb_adr)
        `SEP_OFF_CMD: begin
          if (i_wb_sel[2] && i_wb_dat[`SEP_B_TO]) next_cmd_to = 1'b0; // RULE1
          if (i_wb_sel[2] && i_wb_dat[`SEP_B_LD]) next_cfg_ld = 1'b0; // RULE5
          if (!busy && !boot) begin
            if (i_wb_sel[0]) next_addr[7:0] = i_wb_dat[7:0]; // RULE6
            if (i_wb_sel[1]) next_addr[15:8] = i_wb_dat[15:8];
            if (i_wb_sel[3] && i_wb_dat[`SEP_B_BUSY]) begin
              next_cmd = i_wb_dat[`SEP_CMD_HI:`SEP_CMD_LO];
              if (next_cmd == `SEP_CMD_READ || next_cmd == `SEP_CMD_WRITE || next_cmd == `SEP_CMD_RELOAD) begin
                next_busy = 1'b1;
                next_step = 4'h0;
                next_abort = 1'b0;
                next_retry = 1'b0;
                next_state = SEP_ISSUE;
                if (next_cmd == `SEP_CMD_RELOAD) begin
                  next_cfg_ld = 1'b0; // RULE4
                  next_ovf = 1'b0;
                end
              end else begin
                fail_evt = 1'b1; // RULE9
              end
            end
          end
        end
        `SEP_OFF_DATA: if (i_wb_sel[0] && !busy) next_data = i_wb_dat[7:0]; // RULE7
        `SEP_OFF_IST:  if (i_wb_sel[0]) next_ist = ist & ~i_wb_dat[2:0];
        `SEP_OFF_IMSK: if (i_wb_sel[0]) next_imsk = i_wb_dat[2:0];
        default: ;
      endcase
    end

    // Completion
    if (fin) begin
      next_busy = 1'b0;
      next_state = SEP_IDLE;
      next_ist[`SEP_IRQ_DONE] = 1'b1;
      if (!fail_evt && cmd == `SEP_CMD_RELOAD && ld_sig == `SEP_SIG) begin
        if ({16'h0, ld_len} + `SEP_HDR_LEN > 32'(EE_BYTES)) begin
          next_ovf = 1'b1; // RULE10
        end else begin
          next_cfg_ld = 1'b1; // RULE3
          next_ist[`SEP_IRQ_LD] = 1'b1;
        end
      end
    end
    if (fail_evt) begin
      next_cmd_to = 1'b1; // RULE1
      next_ist[`SEP_IRQ_TO] = 1'b1;
    end
    next_irq = |(next_ist & next_imsk);
  end

  // ==========================================================
  // Registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SEP_IDLE;       act <= SEP_A_END;        div <= 16'h0;
      qcnt <= 2'h0;            bcnt <= 4'h0;            shift <= 9'h1ff;
      step <= 4'h0;            cmd <= `SEP_CMD_READ;    busy <= 1'b0;
      abort <= 1'b0;           retry <= 1'b0;           boot <= 1'b1;
      wr_cnt <= 32'h0;         addr <= `SEP_ADDR_RST;   data <= `SEP_DATA_RST;
      cmd_to <= 1'b0;          cfg_ld <= 1'b0;          ovf <= 1'b0;
      ld_sig <= 8'h00;         ld_len <= 16'h0000;      ist <= `SEP_IRQ_RST;
      imsk <= `SEP_IRQ_RST;    o_wb_dat <= 32'h0;       o_wb_ack <= 1'b0;
      o_sda_oe <= 1'b0;        o_scl_oe <= 1'b0;        o_irq <= 1'b0;
    end else begin
      state <= next_state;     act <= next_act;         div <= next_div;
      qcnt <= next_qcnt;       bcnt <= next_bcnt;       shift <= next_shift;
      step <= next_step;       cmd <= next_cmd;         busy <= next_busy;
      abort <= next_abort;     retry <= next_retry;     boot <= next_boot;
      wr_cnt <= next_wr_cnt;   addr <= next_addr;       data <= next_data;
      cmd_to <= next_cmd_to;   cfg_ld <= next_cfg_ld;   ovf <= next_ovf;
      ld_sig <= next_ld_sig;   ld_len <= next_ld_len;   ist <= next_ist;
      imsk <= next_imsk;       o_wb_dat <= next_wb_dat; o_wb_ack <= next_wb_ack;
      o_sda_oe <= next_sda_oe; o_scl_oe <= next_scl_oe; o_irq <= next_irq;
    end
  end

  // ==========================================================
  // Assertions
  to_rise_cause_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE1
    $rose(cmd_to) |-> $past(fail_evt)) else $error("timeout flag rose without a failure");
  to_w1c_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE1
    (wr && i_wb_adr == `SEP_OFF_CMD && i_wb_sel[2] && i_wb_dat[`SEP_B_TO] && !fail_evt) |=> !cmd_to)
    else $error("timeout flag not cleared by write of one");
  wr_abandon_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE2
    (state == SEP_ISSUE && cmd == `SEP_CMD_WRITE && step == `SEP_STEP_POLL && wr_cnt >= WR_TO_CYC)
    |=> (state == SEP_IDLE && !busy && cmd_to)) else $error("write poll not abandoned");
  ld_valid_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE3
    $rose(cfg_ld) |-> ($past(ld_sig) == `SEP_SIG && $past(fin) && !$past(fail_evt)))
    else $error("loaded flag set without a good load");
  ld_reload_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE4
    ($rose(busy) && cmd == `SEP_CMD_RELOAD) |-> !cfg_ld) else $error("loaded flag kept over reload");
  ld_w1c_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE5
    (wr && i_wb_adr == `SEP_OFF_CMD && i_wb_sel[2] && !i_wb_dat[`SEP_B_LD] && !fin && !i_wb_dat[`SEP_B_BUSY])
    |=> cfg_ld == $past(cfg_ld)) else $error("loaded flag changed by write of zero");
  addr_store_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE6
    (wr && i_wb_adr == `SEP_OFF_CMD && i_wb_sel[1:0] == 2'h3 && !busy && !boot)
    |=> addr == $past(i_wb_dat[15:0])) else $error("address field not written");
  data_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE7
    (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_adr == `SEP_OFF_DATA)
    |=> (o_wb_ack && o_wb_dat == {24'h0, $past(data)})) else $error("data register read wrong");
  unsup_cmd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE9
    (wr && i_wb_adr == `SEP_OFF_CMD && i_wb_sel[3] && i_wb_dat[`SEP_B_BUSY] && !busy && !boot
     && i_wb_dat[`SEP_CMD_HI:`SEP_CMD_LO] == 3'h1) |=> (!busy && cmd_to))
    else $error("unsupported command not flagged");
  ovf_cause_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE10
    $rose(ovf) |-> ($past(cmd) == `SEP_CMD_RELOAD && !cfg_ld)) else $error("overflow without a reload");
  nack_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE11
    $rose(abort) |-> ##[1:1000] (!busy && cmd_to)) else $error("missing ack did not end in timeout");
endmodule

// file: tb/sep_eeprom_model.sv
`timescale 1ns/1ns
// ==========================================================
// Behavioural I2C serial EEPROM, 16 bytes, answers at a0/a1
module sep_eeprom_model (
  // Bus lines as seen on the wires
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  // Misbehaviour the bench may command
  input  wire logic        i_nack_all,
  input  wire logic [31:0] i_poll_nacks,
  // High pulls SDA low
  output logic             o_pull
);
  logic [7:0]  mem [0:15];
  logic [7:0]  sh;
  logic [15:0] ptr;
  int          bit_n;
  int          byte_cnt;
  int          poll_left;
  logic        active;
  logic        rd_mode;
  logic        stored;

  initial begin
    o_pull = 1'b0;
    stored = 1'b0;
    active = 1'b0;
    rd_mode = 1'b0;
    bit_n = 0;
    byte_cnt = 0;
    poll_left = 0;
    sh = 8'h00;
    ptr = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 8'hff;
    // Header: signature, length 0x0002
    mem[0] = 8'ha5;
    mem[1] = 8'h00;
    mem[2] = 8'h02;
  end

  // ==========================================================
  // Start and stop conditions
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    active = 1'b1;
    bit_n = 0;
    byte_cnt = 0;
    rd_mode = 1'b0;
    stored = 1'b0;
  end

  // Internal write cycle keeps the part deaf to polls for a while
  always @(posedge i_sda) if (i_scl === 1'b1) begin
    if (active && stored) poll_left = i_poll_nacks;
    active = 1'b0;
    rd_mode = 1'b0;
    o_pull = 1'b0;
  end

  // ==========================================================
  // Bit sampling on SCL high, driving on SCL low
  always @(posedge i_scl) if (active) begin
    if (bit_n == 8) begin
      bit_n = 0;
      // Master NACK ends a read, so SDA is free for the stop
      if (rd_mode && byte_cnt > 1 && i_sda) rd_mode = 1'b0;
    end else begin
      sh = {sh[6:0], i_sda};
      bit_n++;
    end
  end

  always @(negedge i_scl) if (active) begin
    o_pull = 1'b0;
    if (bit_n == 8) begin
      if (byte_cnt == 0) begin
        if (sh[7:1] != 7'h50 || i_nack_all || poll_left > 0) begin
          if (poll_left > 0) poll_left--;
          active = 1'b0;
        end else begin
          rd_mode = sh[0];
          o_pull = 1'b1;
        end
      end else if (rd_mode) begin
        ptr++;
      end else begin
        if (byte_cnt == 1) ptr[15:8] = sh;
        else if (byte_cnt == 2) ptr[7:0] = sh;
        else begin
          mem[ptr[3:0]] = sh;
          stored = 1'b1;
          ptr++;
        end
        o_pull = 1'b1;
      end
      byte_cnt++;
    end else if (rd_mode && byte_cnt > 0) begin
      o_pull = ~mem[ptr[3:0]][7 - bit_n];
    end
  end
endmodule

// file: tb/serial_eeprom_command_port_test.sv
`timescale 1ns/1ns
`include "sep_consts.svh"
module serial_eeprom_command_port_test;
  localparam int WR_TO = 2000;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        sda_oe;
  logic        scl_oe;
  logic        irq;
  logic        pull;
  logic        nack_all;
  int          poll_nacks;
  int          err_count;
  int          n_compared;
  logic [31:0] q;
  logic [7:0]  sig_t [0:2];
  logic [7:0]  len_t [0:2];
  logic [31:0] exp_t [0:2];
  time         t0;
  wire         sda_w = ~(sda_oe | pull);
  wire         scl_w = ~scl_oe;

  sep_top #(.QCYC(4), .WR_TO_CYC(WR_TO), .EE_BYTES(8)) dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sda(sda_w),
    .o_sda_oe(sda_oe), .o_scl_oe(scl_oe), .o_irq(irq));
  sep_eeprom_model ee_u (.i_scl(scl_w), .i_sda(sda_w), .i_nack_all(nack_all), .i_poll_nacks(poll_nacks),
    .o_pull(pull));

  // ==========================================================
  // Checking and closing
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // Pin is registered: let two edges land before looking
  task automatic chk_pin(input string name, input logic e);
    repeat (2) @(posedge clk);
    #1;
    n_compared++;
    if (irq !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", name, e, irq);
    end
    @(posedge clk);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Wishbone classic master, entered just after a rising edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(`SEP_OFF_CMD);
      n++;
    end while (q[`SEP_B_BUSY] !== 1'b0 && n < 3000);
  endtask

  task automatic run(input logic [2:0] c, input logic [15:0] a);
    wb(1'b1, `SEP_OFF_CMD, 4'b1011, {1'b1, c, 12'h000, a});
    wait_idle;
  endtask

  task automatic ee_put(input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, `SEP_OFF_DATA, 4'h1, {24'h0, d});
    run(`SEP_CMD_WRITE, a);
  endtask

  // ==========================================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    stop_test;
  end

  initial begin
    {rst_n, cyc, stb, we, adr, sel, wdat, nack_all} = '0;
    poll_nacks = 3;
    err_count = 0;
    n_compared = 0;
    sig_t = '{8'ha5, 8'ha5, 8'h00};
    len_t = '{8'h02, 8'h08, 8'h02};
    exp_t = '{32'h0001_0000, 32'h0004_0000, 32'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wait_idle;
    chk("boot cmd", 32'h7001_0000, q);
    rd(`SEP_OFF_DATA);
    chk("data reset", 32'h0, q);
    rd(`SEP_OFF_IST);
    chk("boot status", 32'h5, q);
    wb(1'b1, `SEP_OFF_IST, 4'h1, 32'h7);
    wb(1'b1, `SEP_OFF_IMSK, 4'h1, 32'h2);
    chk_pin("irq quiet", 1'b0);
    wb(1'b1, `SEP_OFF_CMD, 4'h8, 32'h9000_0000);
    wait_idle;
    chk("bad command", 32'h0002_0000, q & 32'h8002_0000);
    chk_pin("irq raised", 1'b1);
    wb(1'b1, `SEP_OFF_IMSK, 4'h1, 32'h0);
    chk_pin("irq masked", 1'b0);
    wb(1'b1, `SEP_OFF_IMSK, 4'h1, 32'h2);
    wb(1'b1, `SEP_OFF_IST, 4'h1, 32'h2);
    chk_pin("irq cleared", 1'b0);
    wb(1'b1, `SEP_OFF_CMD, 4'h4, 32'h0002_0000);
    rd(`SEP_OFF_CMD);
    chk("timeout clear", 32'h0, q & 32'h0002_0000);
    wb(1'b1, `SEP_OFF_CMD, 4'h4, 32'h0);
    rd(`SEP_OFF_CMD);
    chk("loaded kept", 32'h0001_0000, q & 32'h0001_0000);
    wb(1'b1, `SEP_OFF_CMD, 4'h4, 32'h0001_0000);
    rd(`SEP_OFF_CMD);
    chk("loaded clear", 32'h0, q & 32'h0001_0000);
    ee_put(16'h0005, 8'h5a);
    chk("write done", 32'h0000_0005, q & 32'h8002_ffff);
    chk("eeprom byte", 32'h5a, {24'h0, ee_u.mem[5]});
    wb(1'b1, `SEP_OFF_DATA, 4'h1, 32'h0);
    wb(1'b1, `SEP_OFF_CMD, 4'b1011, {1'b1, `SEP_CMD_READ, 12'h000, 16'h0005});
    // Address writes while busy must not move the pointer
    wb(1'b1, `SEP_OFF_CMD, 4'h3, 32'h0000_0fff);
    wait_idle;
    chk("busy address", 32'h0000_0005, q & 32'h0002_ffff);
    rd(`SEP_OFF_DATA);
    chk("read byte", 32'h0000_005a, q);
    wb(1'b1, 12'h100, 4'hf, 32'hffff_ffff);
    rd(12'h100);
    chk("unmapped", 32'h0, q);
    for (int i = 0; i < 3; i++) begin
      ee_put(16'h0000, sig_t[i]);
      ee_put(16'h0002, len_t[i]);
      run(`SEP_CMD_RELOAD, 16'h0000);
      chk("reload flags", exp_t[i], q & 32'h0007_0000);
    end
    nack_all <= 1'b1;
    run(`SEP_CMD_READ, 16'h0005);
    chk("nack fail", 32'h0002_0000, q & 32'h8002_0000);
    nack_all <= 1'b0;
    wb(1'b1, `SEP_OFF_CMD, 4'h4, 32'h0002_0000);
    // Part stays deaf to polls: the write is given up
    poll_nacks <= 1000;
    t0 = $time;
    ee_put(16'h0006, 8'h33);
    chk("write timeout", 32'h0002_0000, q & 32'h8002_0000);
    chk("timeout span", 32'h1, {31'h0, ($time - t0) >= WR_TO * 10});
    stop_test;
  end
endmodule
